// ==== core/qa_watchdog.sv ====
// Question-and-answer watchdog: SPI register access, answer check, windows, error counter.
// Assumes SPI mode 0 pins from another domain and a seed generator on sys_clk.
`timescale 1ns/100ps
`include "qa_watchdog_params.svh"

// Operation
// - Reading the shared seed/answer register is a seed request returning a seed.
// - Answer write is no request; reply carries the seed that answer relates to.
// - Answer window opens after 8-bit start count of ticks, default 0xFF.
// - Answer window closes at start plus 6-bit delta, default 0x30.
// - Answer acceptance ends at start, delta plus 6-bit timeout; then an error event, or a fault reset with timeout reset enable.
// - Request window opens after 8-bit start count from last answer, default 0xFF.
// - Request window closes at start plus 6-bit delta, default 0x30.
// - Request acceptance ends at start, delta plus timeout delta; then an error event, or a fault reset with timeout reset enable.
// - Configuration is writable only while idle: before the first seed request and again after a fault reset.
// - Fault reset keeps configuration; only power state reset loads defaults.
// - Reset enable, default 1, gates the watchdog reset output.
// - Request check enable, default 0, turns request window checking on.
// - Timeout reset enable, default 0, lets a timeout cause the reset.
// - Divide select picks a 64 us tick when clear, 256 us when set.
// - Low threshold, default 7, keeps drivers off while counter below it.
// - High threshold, default 15, switches drivers on; hysteresis between thresholds.
// - Good step, default 1, is added to the counter on each good event.
// - Bad step, default 3, is subtracted from the counter on each error.
// - Four-bit error counter collects good and bad request and answer events.
// - Expected answer: low byte is the complemented seed, high byte the seed.
// - Counter at zero sets the zero flag; reset only when reset enable set.
module qa_watchdog #(
   parameter int TICK_FAST = `TICK_FAST_CYCLES,
   parameter int TICK_SLOW = `TICK_SLOW_CYCLES
) (
   input  wire logic       sys_clk,                 // System clock, 200 MHz.
   input  wire logic       reset,                   // Power state reset, high.
   input  wire logic       spi_cs_n,                // Chip select pin, low active.
   input  wire logic       spi_sclk,                // Serial clock pin.
   input  wire logic       spi_mosi,                // Serial data in pin.
   input  wire logic [7:0] next_seed_word,          // Seed from the generator.
   output logic            spi_miso,                // Serial data out pin.
   output logic            watchdog_reset_output,   // Fault reset pulse.
   output logic            drivers_enable,          // Load drivers allowed.
   output logic            counter_zero_reset_flag, // Counter reached zero.
   output logic [3:0]      error_event_counter,     // Error counter value.
   output logic            seed_advance             // Generator step pulse.
);

   qa_watchdog_pkg::wd_state_s s;
   qa_watchdog_pkg::wd_state_s next_s;

   // ========================================================================
   // Helpers
   // ========================================================================
   function automatic logic [2:0] frame_crc(input logic [28:0] body);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 0; i < 29; i++) begin
         c[i % 3] = c[i % 3] ^ body[i];
      end
      return c;
   endfunction : frame_crc

   function automatic logic in_window(input logic [8:0] t,
                                      input qa_watchdog_pkg::window_s w);
      logic [8:0] lo;
      logic [8:0] hi;
      lo = {1'b0, w.start};
      hi = lo + {3'h0, w.end_delta};
      return (t >= lo) && (t < hi);
   endfunction : in_window

   function automatic logic [8:0] timeout_at(input qa_watchdog_pkg::window_s w);
      return {1'b0, w.start} + {3'h0, w.end_delta} + {3'h0, w.tmo};
   endfunction : timeout_at

   // ========================================================================
   // Next state
   // ========================================================================
   always_comb begin
      logic        rise;
      logic        fall;
      logic        frame_end;
      logic        wr;
      logic [6:0]  addr;
      logic [31:0] f;
      logic        is_req;
      logic        is_ans;
      logic        tick;
      logic        good;
      logic        bad;
      logic        tmo;
      logic        correct;
      logic [15:0] limit;
      logic [4:0]  sum;
      logic [20:0] payload;
      logic [28:0] body;
      next_s = s;
      next_s.fault = 1'b0;
      next_s.seed_advance = 1'b0;
      good = 1'b0;
      bad = 1'b0;
      tmo = 1'b0;
      tick = 1'b0;
      payload = 21'h0;
      body = 29'h0;
      next_s.cs_sync = {s.cs_sync[0], spi_cs_n};
      next_s.sclk_sync = {s.sclk_sync[0], spi_sclk};
      next_s.mosi_sync = {s.mosi_sync[0], spi_mosi};
      next_s.cs_d = s.cs_sync[1];
      next_s.sclk_d = s.sclk_sync[1];
      rise = s.sclk_sync[1] & ~s.sclk_d & ~s.cs_sync[1];
      fall = ~s.sclk_sync[1] & s.sclk_d & ~s.cs_sync[1];
      frame_end = s.cs_sync[1] & ~s.cs_d;
      if (!s.cs_sync[1] && s.cs_d) begin
         next_s.bit_cnt = 6'h0;
      end
      // Bits are taken on the rising edge, MSB first.
      if (rise) begin
         next_s.shift_in = {s.shift_in[30:0], s.mosi_sync[1]};
         if (s.bit_cnt != `FRAME_BITS) begin
            next_s.bit_cnt = s.bit_cnt + 6'h1;
         end
      end
      if (fall) begin
         next_s.shift_out = {s.shift_out[30:0], 1'b0};
         next_s.miso = s.shift_out[30];
      end
      f = s.shift_in;
      wr = f[`FRAME_WRITE_BIT];
      addr = f[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
      // A frame shorter than 32 bits is dropped whole; a longer one keeps its last 32 bits.
      is_req = frame_end && (s.bit_cnt == `FRAME_BITS) && !wr && (addr == `ADDR_RESPONSE);
      is_ans = frame_end && (s.bit_cnt == `FRAME_BITS) && wr && (addr == `ADDR_RESPONSE);

      // Configuration locks once the watchdog has left idle.
      if (frame_end && (s.bit_cnt == `FRAME_BITS) && wr &&
          (s.state == qa_watchdog_pkg::WD_IDLE)) begin
         case (addr)
            `ADDR_RESP_TIMING: begin
               next_s.resp_win.start = f[`WIN_START_HI:`WIN_START_LO];
               next_s.resp_win.end_delta = f[`WIN_END_HI:`WIN_END_LO];
               next_s.resp_win.tmo = f[`WIN_TMO_HI:`WIN_TMO_LO];
            end
            `ADDR_REQ_TIMING: begin
               next_s.req_win.start = f[`WIN_START_HI:`WIN_START_LO];
               next_s.req_win.end_delta = f[`WIN_END_HI:`WIN_END_LO];
               next_s.req_win.tmo = f[`WIN_TMO_HI:`WIN_TMO_LO];
            end
            `ADDR_COUNTER: begin
               next_s.cfg.reset_output_enable = f[`RST_EN_BIT];
               next_s.cfg.request_check_enable = f[`REQ_CHECK_BIT];
               next_s.cfg.timeout_reset_enable = f[`TMO_RST_BIT];
               next_s.cfg.tick_divide_select = f[`DIV_SEL_BIT];
               next_s.cfg.driver_inhibit_threshold = f[`TH_LOW_HI:`TH_LOW_LO];
               next_s.cfg.driver_activate_threshold = f[`TH_HIGH_HI:`TH_HIGH_LO];
               next_s.cfg.good_event_step = f[`GOOD_STEP_HI:`GOOD_STEP_LO];
               next_s.cfg.bad_event_step = f[`BAD_STEP_HI:`BAD_STEP_LO];
            end
            default: begin
            end
         endcase
      end

      // Tick prescaler and window timer.
      limit = s.cfg.tick_divide_select ? 16'(TICK_SLOW - 1) : 16'(TICK_FAST - 1);
      if (s.state != qa_watchdog_pkg::WD_IDLE) begin
         if (s.prescale >= limit) begin
            next_s.prescale = 16'h0;
            tick = 1'b1;
         end else begin
            next_s.prescale = s.prescale + 16'h1;
         end
      end
      if (tick && (s.timer != `TIMER_MAX)) begin
         next_s.timer = s.timer + 9'h1;
      end

      correct = (f[`ANS_LOW_HI:`ANS_LOW_LO] == ~s.seed_word) &&
                (f[`ANS_HIGH_HI:`ANS_HIGH_LO] == s.seed_word);
      case (s.state)
         qa_watchdog_pkg::WD_IDLE: begin
            if (is_req) begin
               next_s.state = qa_watchdog_pkg::WD_WAIT_ANSW;
               next_s.timer = 9'h0;
               next_s.prescale = 16'h0;
            end
         end
         qa_watchdog_pkg::WD_WAIT_ANSW: begin
            if (is_req) begin
               // The old seed is served again and the window restarts.
               bad = 1'b1;
               next_s.timer = 9'h0;
            end else if (is_ans) begin
               next_s.timer = 9'h0;
               next_s.state = qa_watchdog_pkg::WD_WAIT_REQ;
               if (correct && in_window(s.timer, s.resp_win)) begin
                  good = 1'b1;
                  next_s.seed_pending = 1'b1;
               end else begin
                  bad = 1'b1;
               end
            end else if (s.timer >= timeout_at(s.resp_win)) begin
               tmo = 1'b1;
            end
         end
         qa_watchdog_pkg::WD_WAIT_REQ: begin
            if (is_req) begin
               next_s.timer = 9'h0;
               next_s.state = qa_watchdog_pkg::WD_WAIT_ANSW;
               if (s.cfg.request_check_enable) begin
                  good = in_window(s.timer, s.req_win);
                  bad = !in_window(s.timer, s.req_win);
               end
            end else if (is_ans) begin
               bad = 1'b1;
            end else if (s.timer >= timeout_at(s.req_win)) begin
               tmo = 1'b1;
            end
         end
         default: begin
            next_s.state = qa_watchdog_pkg::WD_IDLE;
         end
      endcase

      // A fresh seed is taken at the first request after power reset, else only at the request after a correct answer inside the answer window.
      if (is_req && s.seed_pending) begin
         next_s.seed_word = next_seed_word;
         next_s.seed_pending = 1'b0;
         next_s.seed_advance = 1'b1;
      end

      if (tmo) begin
         next_s.timer = 9'h0;
         if (s.cfg.timeout_reset_enable) begin
            next_s.fault = s.cfg.reset_output_enable;
         end else begin
            bad = 1'b1;
         end
      end

      // Error event counter, saturating at both ends.
      sum = {1'b0, s.error_event_counter} + {2'h0, s.cfg.good_event_step};
      if (bad) begin
         if (s.error_event_counter > {1'b0, s.cfg.bad_event_step}) begin
            next_s.error_event_counter = s.error_event_counter - {1'b0, s.cfg.bad_event_step};
         end else begin
            next_s.error_event_counter = 4'h0;
            next_s.counter_zero_reset_flag = 1'b1;
            next_s.fault = s.cfg.reset_output_enable;
         end
      end else if (good) begin
         next_s.error_event_counter = (sum > `COUNT_MAX) ? 4'hF : sum[3:0];
      end

      // Driver hysteresis; the host keeps the low threshold below the high one.
      if (next_s.error_event_counter < s.cfg.driver_inhibit_threshold) begin
         next_s.drivers_on = 1'b0;
      end else if (next_s.error_event_counter >= s.cfg.driver_activate_threshold) begin
         next_s.drivers_on = 1'b1;
      end

      // Configuration survives a fault; the sequence restarts from idle.
      if (next_s.fault) begin
         next_s.state = qa_watchdog_pkg::WD_IDLE;
         next_s.error_event_counter = `DEF_COUNT;
         next_s.timer = 9'h0;
      end

      // Reply is shifted out during the next frame.
      if (frame_end && (s.bit_cnt == `FRAME_BITS)) begin
         case (addr)
            `ADDR_RESPONSE: payload = {13'h0, (is_ans ? s.seed_word : next_s.seed_word)};
            `ADDR_RESP_TIMING: payload = {1'b0, s.resp_win};
            `ADDR_REQ_TIMING: payload = {1'b0, s.req_win};
            `ADDR_COUNTER: payload = {3'h0, s.cfg};
            default: payload = 21'h0;
         endcase
         body = {1'b0, addr, payload};
         next_s.shift_out = {body, frame_crc(body)};
         next_s.miso = 1'b0;
      end
   end

   // ========================================================================
   // State register
   // ========================================================================
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s <= '0;
         s.cs_sync <= 2'h3;
         s.cs_d <= 1'b1;
         s.resp_win <= '{tmo: `DEF_WIN_TMO, end_delta: `DEF_WIN_END, start: `DEF_WIN_START};
         s.req_win <= '{tmo: `DEF_WIN_TMO, end_delta: `DEF_WIN_END, start: `DEF_WIN_START};
         s.cfg.reset_output_enable <= 1'b1;
         s.cfg.driver_inhibit_threshold <= `DEF_TH_LOW;
         s.cfg.driver_activate_threshold <= `DEF_TH_HIGH;
         s.cfg.good_event_step <= `DEF_GOOD_STEP;
         s.cfg.bad_event_step <= `DEF_BAD_STEP;
         s.state <= qa_watchdog_pkg::WD_IDLE;
         s.error_event_counter <= `DEF_COUNT;
         s.seed_pending <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign spi_miso = s.miso;
   assign watchdog_reset_output = s.fault;
   assign drivers_enable = s.drivers_on;
   assign counter_zero_reset_flag = s.counter_zero_reset_flag;
   assign error_event_counter = s.error_event_counter;
   assign seed_advance = s.seed_advance;

endmodule : qa_watchdog

// ==== core/qa_watchdog_params.svh ====
// Constants of the question-and-answer watchdog: frame layout, addresses, defaults, timing.
// Included by the package and the design; holds definitions only.
`ifndef QA_WATCHDOG_PARAMS_SVH
`define QA_WATCHDOG_PARAMS_SVH

// ==========================================================================
// Frame layout
// ==========================================================================
`define FRAME_BITS        6'd32
`define FRAME_WRITE_BIT   31
`define FRAME_ADDR_HI     30
`define FRAME_ADDR_LO     24
`define FRAME_DATA_HI     23
`define FRAME_DATA_LO     3

// ==========================================================================
// Register addresses
// ==========================================================================
`define ADDR_RESPONSE     7'h10
`define ADDR_RESP_TIMING  7'h11
`define ADDR_REQ_TIMING   7'h12
`define ADDR_COUNTER      7'h13

// ==========================================================================
// Field positions inside the frame
// ==========================================================================
`define ANS_HIGH_HI       18
`define ANS_HIGH_LO       11
`define ANS_LOW_HI        10
`define ANS_LOW_LO        3
`define WIN_START_HI      10
`define WIN_START_LO      3
`define WIN_END_HI        16
`define WIN_END_LO        11
`define WIN_TMO_HI        22
`define WIN_TMO_LO        17
`define BAD_STEP_HI       5
`define BAD_STEP_LO       3
`define GOOD_STEP_HI      8
`define GOOD_STEP_LO      6
`define TH_HIGH_HI        12
`define TH_HIGH_LO        9
`define TH_LOW_HI         16
`define TH_LOW_LO         13
`define DIV_SEL_BIT       17
`define TMO_RST_BIT       18
`define REQ_CHECK_BIT     19
`define RST_EN_BIT        20

// ==========================================================================
// Reset values and counter limit
// ==========================================================================
`define DEF_WIN_START     8'hFF
`define DEF_WIN_END       6'h30
`define DEF_WIN_TMO       6'h00
`define DEF_TH_LOW        4'h7
`define DEF_TH_HIGH       4'hF
`define DEF_GOOD_STEP     3'h1
`define DEF_BAD_STEP      3'h3
`define DEF_COUNT         4'h7
`define COUNT_MAX         5'h0F

// ==========================================================================
// Timing
// ==========================================================================
`define SYS_CLK_NS        5
`define TICK_FAST_NS      64000
`define TICK_SLOW_NS      256000
`define TICK_FAST_CYCLES  (`TICK_FAST_NS / `SYS_CLK_NS)
`define TICK_SLOW_CYCLES  (`TICK_SLOW_NS / `SYS_CLK_NS)
`define TIMER_MAX         9'h1FF

`endif

// ==== core/qa_watchdog_pkg.sv ====
// Types of the question-and-answer watchdog.
// Needs the constants header on the include path.
`include "qa_watchdog_params.svh"

package qa_watchdog_pkg;

   typedef enum logic [1:0] {
      WD_IDLE      = 2'b00,
      WD_WAIT_ANSW = 2'b01,
      WD_WAIT_REQ  = 2'b10
   } wd_state_e;

   typedef struct packed {
      logic [5:0] tmo;
      logic [5:0] end_delta;
      logic [7:0] start;
   } window_s;

   typedef struct packed {
      logic       reset_output_enable;
      logic       request_check_enable;
      logic       timeout_reset_enable;
      logic       tick_divide_select;
      logic [3:0] driver_inhibit_threshold;
      logic [3:0] driver_activate_threshold;
      logic [2:0] good_event_step;
      logic [2:0] bad_event_step;
   } counter_cfg_s;

   typedef struct packed {
      logic [1:0]   cs_sync;
      logic [1:0]   sclk_sync;
      logic [1:0]   mosi_sync;
      logic         cs_d;
      logic         sclk_d;
      logic [31:0]  shift_in;
      logic [5:0]   bit_cnt;
      logic [31:0]  shift_out;
      logic         miso;
      window_s      resp_win;
      window_s      req_win;
      counter_cfg_s cfg;
      wd_state_e    state;
      logic [15:0]  prescale;
      logic [8:0]   timer;
      logic [3:0]   error_event_counter;
      logic         drivers_on;
      logic         fault;
      logic         counter_zero_reset_flag;
      logic [7:0]   seed_word;
      logic         seed_pending;
      logic         seed_advance;
   } wd_state_s;

endpackage : qa_watchdog_pkg

// ==== tb/qa_watchdog_properties.sv ====
// Concurrent checks on the watchdog outputs against its serial pins.
// Bound to every watchdog instance; it sees the top module's ports only.
`timescale 1ns/100ps
module qa_watchdog_properties #(
   parameter int TICK_FAST = 12800,
   parameter int TICK_SLOW = 51200
) (
   input wire logic       sys_clk,                 // System clock.
   input wire logic       reset,                   // Power state reset.
   input wire logic       spi_cs_n,                // Chip select pin.
   input wire logic       spi_sclk,                // Serial clock pin.
   input wire logic       spi_mosi,                // Serial data in.
   input wire logic [7:0] next_seed_word,          // Seed from generator.
   input wire logic       spi_miso,                // Serial data out.
   input wire logic       watchdog_reset_output,   // Fault reset pulse.
   input wire logic       drivers_enable,          // Drivers allowed.
   input wire logic       counter_zero_reset_flag, // Counter hit zero.
   input wire logic [3:0] error_event_counter,     // Error counter.
   input wire logic       seed_advance             // Seed step pulse.
);
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   a_reset_values: assert property (disable iff (1'h0)
      reset |=> !spi_miso && !watchdog_reset_output && !drivers_enable
      && !counter_zero_reset_flag && !seed_advance && error_event_counter == 4'h7)
      else $error("outputs not at reset values");
   a_fault_single_pulse: assert property (
      watchdog_reset_output |=> !watchdog_reset_output)
      else $error("fault reset wider than one cycle");
   a_fault_reloads_count: assert property (
      watchdog_reset_output |-> ##[0:2] error_event_counter == 4'h7)
      else $error("counter not reloaded after fault");
   a_zero_sets_flag: assert property (
      error_event_counter == 4'h0 |-> ##[0:1] counter_zero_reset_flag)
      else $error("zero flag missing");
   a_flag_stays_set: assert property (
      counter_zero_reset_flag |=> counter_zero_reset_flag)
      else $error("zero flag dropped");
   a_zero_drivers_off: assert property (
      error_event_counter == 4'h0 |-> ##[0:1] !drivers_enable)
      else $error("drivers on at zero count");
   a_full_drivers_on: assert property (
      error_event_counter == 4'hF |-> ##[0:1] drivers_enable)
      else $error("drivers off at full count");
   a_drivers_need_count: assert property (
      $rose(drivers_enable) |-> error_event_counter >= 4'h2)
      else $error("drivers switched on too low");
   a_step_bounded: assert property (
      error_event_counter > $past(error_event_counter)
      |-> error_event_counter - $past(error_event_counter) <= 4'h7)
      else $error("counter rose by more than a step");
   a_seed_single_pulse: assert property (
      seed_advance |=> !seed_advance)
      else $error("seed step wider than one cycle");
   a_seed_after_frame: assert property (
      seed_advance |-> spi_cs_n)
      else $error("seed stepped inside a frame");
   a_miso_sclk_low: assert property (
      $changed(spi_miso) |-> !spi_sclk)
      else $error("reply bit changed while clock high");
endmodule : qa_watchdog_properties

bind qa_watchdog qa_watchdog_properties #(.TICK_FAST(TICK_FAST), .TICK_SLOW(TICK_SLOW)) u_props (
   .sys_clk(sys_clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
   .spi_mosi(spi_mosi), .next_seed_word(next_seed_word), .spi_miso(spi_miso),
   .watchdog_reset_output(watchdog_reset_output), .drivers_enable(drivers_enable),
   .counter_zero_reset_flag(counter_zero_reset_flag),
   .error_event_counter(error_event_counter), .seed_advance(seed_advance)
);

// ==== tb/spi_host_model.sv ====
// Host side of the serial link: sends 32-bit mode 0 frames and gathers reply bits.
// Assumes the device shows each reply during the frame after the one it answers.
`timescale 1ns/100ps
module spi_host_model #(
   parameter int HALF = 4
) (
   input  wire logic sys_clk,  // Paces the serial clock.
   output logic      spi_cs_n, // Low during a frame.
   output logic      spi_sclk, // Idles low between frames.
   output logic      spi_mosi, // Data to the device.
   input  wire logic spi_miso  // Data from the device.
);
   initial begin
      spi_cs_n = 1'h1;
      spi_sclk = 1'h0;
      spi_mosi = 1'h0;
   end

   function automatic logic [31:0] frame(input logic w, input logic [6:0] a,
                                         input logic [20:0] p);
      logic [28:0] body;
      logic [2:0]  crc;
      body = {w, a, p};
      crc = 3'h0;
      for (int i = 0; i < 29; i++) crc[i % 3] ^= body[i];
      return {body, crc};
   endfunction : frame

   task automatic xfer(input logic [31:0] f, output logic [31:0] r);
      spi_cs_n = 1'h0;
      repeat (HALF) @(negedge sys_clk);
      for (int i = 31; i >= 0; i--) begin
         spi_mosi = f[i];
         repeat (HALF) @(negedge sys_clk);
         spi_sclk = 1'h1;
         r[i] = spi_miso;
         repeat (HALF) @(negedge sys_clk);
         spi_sclk = 1'h0;
      end
      repeat (HALF) @(negedge sys_clk);
      spi_cs_n = 1'h1;
      // A stale data level would hide a device that samples outside the frame.
      spi_mosi = ~spi_mosi;
      repeat (10) @(negedge sys_clk);
   endtask : xfer
endmodule : spi_host_model

// ==== tb/tb.sv ====
// Self-checking bench of the question-and-answer watchdog.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/100ps
`include "qa_watchdog_params.svh"
module tb;
   localparam logic [20:0] WIN = {1'h0, 6'h04, 6'h08, 8'h0C};
   logic        sys_clk;
   logic        reset;
   logic        spi_cs_n;
   logic        spi_sclk;
   logic        spi_mosi;
   logic [7:0]  next_seed_word;
   logic        spi_miso;
   logic        watchdog_reset_output;
   logic        drivers_enable;
   logic        counter_zero_reset_flag;
   logic [3:0]  error_event_counter;
   logic        seed_advance;
   logic [31:0] rep;
   int          num_errors;
   int          total_checks;
   int          faults;
   int          advances;

   qa_watchdog #(.TICK_FAST(32), .TICK_SLOW(64)) u_dut (
      .sys_clk(sys_clk), .reset(reset), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi), .next_seed_word(next_seed_word), .spi_miso(spi_miso),
      .watchdog_reset_output(watchdog_reset_output), .drivers_enable(drivers_enable),
      .counter_zero_reset_flag(counter_zero_reset_flag),
      .error_event_counter(error_event_counter), .seed_advance(seed_advance));
   spi_host_model u_host (.sys_clk(sys_clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso));

   initial begin
      sys_clk = 1'h0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) begin
      if (watchdog_reset_output === 1'h1) faults++;
      if (seed_advance === 1'h1) advances++;
   end

   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : check
   task automatic xf(input logic w, input logic [6:0] a, input logic [20:0] p);
      u_host.xfer(u_host.frame(w, a, p), rep);
   endtask : xf
   task automatic exp_rep(input string name, input logic [6:0] a, input logic [20:0] p);
      check(name, u_host.frame(1'h0, a, p), rep);
   endtask : exp_rep
   task automatic power_reset();
      reset = 1'h1;
      repeat (8) @(negedge sys_clk);
      reset = 1'h0;
      repeat (4) @(negedge sys_clk);
   endtask : power_reset

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic check_defaults();
      xf(1'h0, `ADDR_COUNTER, 21'h0);
      xf(1'h0, `ADDR_RESP_TIMING, 21'h0);
      exp_rep("counter_setup", `ADDR_COUNTER, 21'h021FCB);
      xf(1'h0, `ADDR_REQ_TIMING, 21'h0);
      exp_rep("response_window_timing", `ADDR_RESP_TIMING, 21'h0030FF);
      xf(1'h0, 7'h05, 21'h0);
      exp_rep("request_window_timing", `ADDR_REQ_TIMING, 21'h0030FF);
      xf(1'h0, `ADDR_COUNTER, 21'h0);
      exp_rep("unmapped", 7'h05, 21'h0);
      check("error_event_counter", 32'h7, error_event_counter);
      check("drivers_enable", 32'h0, drivers_enable);
      check("counter_zero_reset_flag", 32'h0, counter_zero_reset_flag);
   endtask : check_defaults

   // Frames run back to back, about 8.5 ticks apart, so the window [12,20) is hit by the answer only.
   task automatic question_answer();
      xf(1'h1, `ADDR_RESP_TIMING, WIN);
      xf(1'h1, `ADDR_REQ_TIMING, WIN);
      xf(1'h1, `ADDR_COUNTER, {3'h0, 4'hE, 4'h3, 4'h9, 3'h2, 3'h3});
      next_seed_word = 8'h5A;
      xf(1'h0, `ADDR_RESPONSE, 21'h0);
      check("seed_advance", 32'h1, advances);
      xf(1'h1, `ADDR_COUNTER, {3'h0, 4'h6, 4'h3, 4'h9, 3'h2, 3'h7});
      exp_rep("seed_word", `ADDR_RESPONSE, 21'h00005A);
      xf(1'h1, `ADDR_RESPONSE, {5'h0, 8'h5A, 8'hA5});
      check("error_event_counter", 32'h9, error_event_counter);
      check("drivers_enable", 32'h1, drivers_enable);
      next_seed_word = 8'h33;
      xf(1'h0, `ADDR_RESPONSE, 21'h0);
      exp_rep("response_word", `ADDR_RESPONSE, 21'h00005A);
      check("error_event_counter", 32'h6, error_event_counter);
      check("drivers_enable", 32'h1, drivers_enable);
      check("seed_advance", 32'h2, advances);
      next_seed_word = 8'h44;
      xf(1'h0, `ADDR_RESPONSE, 21'h0);
      exp_rep("seed_word", `ADDR_RESPONSE, 21'h000033);
      check("error_event_counter", 32'h3, error_event_counter);
      xf(1'h0, `ADDR_RESPONSE, 21'h0);
      exp_rep("seed_word", `ADDR_RESPONSE, 21'h000033);
      check("seed_advance", 32'h2, advances);
      check("counter_zero_reset_flag", 32'h1, counter_zero_reset_flag);
      check("watchdog_reset_output", 32'h1, faults);
      check("error_event_counter", 32'h7, error_event_counter);
      check("drivers_enable", 32'h0, drivers_enable);
   endtask : question_answer

   task automatic slow_timeout();
      int n;
      int f0;
      xf(1'h0, `ADDR_RESP_TIMING, 21'h0);
      xf(1'h0, `ADDR_COUNTER, 21'h0);
      exp_rep("response_window_timing", `ADDR_RESP_TIMING, WIN);
      xf(1'h1, `ADDR_COUNTER, {3'h0, 4'hF, 4'h3, 4'h9, 3'h2, 3'h3});
      xf(1'h0, `ADDR_RESPONSE, 21'h0);
      n = 0;
      f0 = faults;
      while (faults == f0 && n < 4000) begin
         @(negedge sys_clk);
         n++;
      end
      // Timeout lands at 24 ticks of 64 cycles, less the frame tail, give or take a tick.
      check("timeout_delay", 32'h1, n > 1450 && n < 1620);
   endtask : slow_timeout

   task automatic conclude();
      $display("checks %0d, errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : conclude

   initial begin
      #200000;
      num_errors++;
      conclude();
   end
   initial begin
      num_errors = 0;
      total_checks = 0;
      faults = 0;
      advances = 0;
      next_seed_word = 8'h00;
      power_reset();
      check_defaults();
      question_answer();
      slow_timeout();
      power_reset();
      check_defaults();
      conclude();
   end
endmodule : tb
